// ### hw/asf_alu_flags.sv
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/1ps

// Overview of operation
// [RL1] Flag register as destination: drop result, update flags only; ops that touch no flag write result[4:0] into the flags instead.
// [RL2] Clear of flag register sets zero flag, others unchanged.
// [RL3] Software should use bit/swap/move ops; these touch no flag.
// [RL4] Upper three flag register bits always read zero.
// [RL5] Sign flag follows result most significant bit.
// [RL6] Wrap flag set on signed overflow of seven-bit magnitude.
// [RL7] Zero flag set when arithmetic or logic result is zero.
// [RL8] Half carry from bit three carry out on add and subtract.
// [RL9] Carry from most significant bit carry out on add and subtract.
// [RL10] Subtract adds two's complement; carries mean inverted borrow.
// [RL11] Rotate loads half carry from source bit four or three.
// [RL12] Rotate loads carry from source low or high bit.
// [RL13] Unaffected flags hold; flags have no reset value.
module asf_alu_flags
    import asf_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire asf_req_t req,
    input wire logic [ASF_AW-1:0] reg_addr,
    input wire logic [ASF_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output asf_res_t res,
    output logic [ASF_DW-1:0] reg_rdata,
    output logic [4:0] flags
);

    // ------------------------------------------------------------
    // Combinational ALU
    // ------------------------------------------------------------
    logic [7:0] result;
    logic [4:0] flags_r;
    logic [4:0] flags_nxt;
    logic arith;
    logic rotate;
    logic logic_op;
    logic [4:0] low_sum;
    logic [8:0] full_sum;
    logic [7:0] addend;
    logic [7:0] augend;
    logic [7:0] last_op_r;
    logic carry_in;

    always_comb
    begin
        addend = req.opb;
        augend = req.opa;
        carry_in = 1'b0;
        // [RL10] Two's complement subtract
        // Carry-in keeps the no-borrow carry when the subtrahend is zero
        if (req.op == ASF_OP_LITERAL_MINUS_ACC
            || req.op == ASF_OP_FILE_MINUS_ACC)
        begin
            addend = ~req.opb;
            carry_in = 1'b1;
        end
        low_sum = {1'b0, augend[3:0]} + {1'b0, addend[3:0]}
            + {4'h0, carry_in};
        full_sum = {1'b0, augend} + {1'b0, addend} + {8'h00, carry_in};
    end

    always_comb
    begin
        arith = 1'b0;
        rotate = 1'b0;
        logic_op = 1'b0;
        result = req.opa;
        case (req.op)
            ASF_OP_ADD_ACC_TO_FILE, ASF_OP_ADD_LITERAL,
            ASF_OP_LITERAL_MINUS_ACC, ASF_OP_FILE_MINUS_ACC:
            begin
                arith = 1'b1;
                result = full_sum[7:0];
            end
            ASF_OP_ROTATE_RIGHT:
            begin
                rotate = 1'b1;
                result = {flags_r[ASF_BIT_CARRY], req.opa[7:1]};
            end
            ASF_OP_ROTATE_LEFT:
            begin
                rotate = 1'b1;
                result = {req.opa[6:0], flags_r[ASF_BIT_CARRY]};
            end
            ASF_OP_CLEAR_FILE:
            begin
                logic_op = 1'b1;
                result = ASF_ZERO_BYTE;
            end
            ASF_OP_LOGIC_AND:
            begin
                logic_op = 1'b1;
                result = req.opa & req.opb;
            end
            ASF_OP_LOGIC_OR:
            begin
                logic_op = 1'b1;
                result = req.opa | req.opb;
            end
            ASF_OP_LOGIC_XOR:
            begin
                logic_op = 1'b1;
                result = req.opa ^ req.opb;
            end
            // [RL3] Bit, swap and move ops leave the flags alone
            ASF_OP_BIT_CLEAR:
            begin
                result = req.opa & ~(ASF_ONE_BYTE << req.bitsel);
            end
            ASF_OP_BIT_SET:
            begin
                result = req.opa | (ASF_ONE_BYTE << req.bitsel);
            end
            ASF_OP_NIBBLE_SWAP:
            begin
                result = {req.opa[3:0], req.opa[7:4]};
            end
            ASF_OP_MOVE:
            begin
                result = req.opa;
            end
            default:
            begin
                result = req.opa;
            end
        endcase
    end

    always_comb
    begin
        // [RL13] Default is hold
        flags_nxt = flags_r;
        if (req.valid && (arith || logic_op || rotate))
        begin
            // [RL5] Sign; [RL2] a clear moves only the zero flag
            if (req.op != ASF_OP_CLEAR_FILE)
            begin
                flags_nxt[ASF_BIT_SIGN] = result[7];
            end
            // [RL7] Zero
            flags_nxt[ASF_BIT_ZERO] = (result == ASF_ZERO_BYTE);
        end
        if (req.valid && arith)
        begin
            // [RL6] Signed overflow: like signs in, other sign out
            flags_nxt[ASF_BIT_WRAP] = (augend[7] == addend[7])
                && (result[7] != augend[7]);
            // [RL8] Half carry out of bit three
            flags_nxt[ASF_BIT_HALF] = low_sum[ASF_NIB];
            // [RL9] Carry out of bit seven
            flags_nxt[ASF_BIT_CARRY] = full_sum[8];
        end
        if (req.valid && rotate)
        begin
            // [RL11] Half carry from source bit four or three
            flags_nxt[ASF_BIT_HALF] = (req.op == ASF_OP_ROTATE_RIGHT)
                ? req.opa[ASF_BIT_SIGN] : req.opa[ASF_BIT_WRAP];
            // [RL12] Carry from low or high source bit
            flags_nxt[ASF_BIT_CARRY] = (req.op == ASF_OP_ROTATE_RIGHT)
                ? req.opa[0] : req.opa[7];
        end
        // [RL1] Flag-neutral op aimed at flags: result[4:0] loaded; flag-affecting ops drop it
        // [RL2] Clear of flags thus only sets zero
        if (req.valid && req.dest_flags && !(arith || logic_op || rotate))
        begin
            flags_nxt = result[4:0];
        end
        else if (reg_wr && reg_addr == ASF_FLAGS_ADDR)
        begin
            // Core write lands only if no instruction owns the flags
            if (!(req.valid && (arith || logic_op || rotate)))
            begin
                flags_nxt = reg_wdata[4:0];
            end
        end
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    // [RL13] No reset: flags power up unknown
    always_ff @(posedge core_clk)
    begin
        flags_r <= flags_nxt;
    end

    always_ff @(posedge core_clk)
    begin
        flags <= flags_nxt;
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            res <= '0;
        end
        else
        begin
            res.valid <= req.valid;
            // [RL1] Suppress result write when flags are destination
            res.write <= req.valid && !req.dest_flags;
            res.data <= result;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            last_op_r <= ASF_ZERO_BYTE;
        end
        else if (req.valid)
        begin
            last_op_r <= {4'h0, req.op};
        end
    end

    // ------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            reg_rdata <= ASF_ZERO_BYTE;
        end
        else if (reg_rd)
        begin
            if (reg_addr == ASF_FLAGS_ADDR)
            begin
                // [RL4] Bits 7-5 read zero
                reg_rdata <= {3'h0, flags_r};
            end
            else if (reg_addr == ASF_LAST_ADDR)
            begin
                reg_rdata <= last_op_r;
            end
            else
            begin
                reg_rdata <= ASF_ZERO_BYTE;
            end
        end
        else
        begin
            reg_rdata <= ASF_ZERO_BYTE;
        end
    end

endmodule // asf_alu_flags

// ### hw/asf_pkg.sv
package asf_pkg;

    // ------------------------------------------------------------
    // Widths and register layout
    // ------------------------------------------------------------
    localparam int ASF_DW = 8;
    localparam int ASF_AW = 4;
    localparam logic [3:0] ASF_FLAGS_ADDR = 4'h0;
    localparam logic [3:0] ASF_LAST_ADDR = 4'h1;
    localparam int ASF_BIT_SIGN = 4;
    localparam int ASF_BIT_WRAP = 3;
    localparam int ASF_BIT_ZERO = 2;
    localparam int ASF_BIT_HALF = 1;
    localparam int ASF_BIT_CARRY = 0;
    localparam int ASF_NIB = 4;
    localparam logic [7:0] ASF_ZERO_BYTE = 8'h00;
    localparam logic [7:0] ASF_ONE_BYTE = 8'h01;

    // ------------------------------------------------------------
    // Operation codes
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ASF_OP_NONE = 4'h0,
        ASF_OP_ADD_ACC_TO_FILE = 4'h1,
        ASF_OP_ADD_LITERAL = 4'h2,
        ASF_OP_LITERAL_MINUS_ACC = 4'h3,
        ASF_OP_FILE_MINUS_ACC = 4'h4,
        ASF_OP_ROTATE_RIGHT = 4'h5,
        ASF_OP_ROTATE_LEFT = 4'h6,
        ASF_OP_CLEAR_FILE = 4'h7,
        ASF_OP_LOGIC_AND = 4'h8,
        ASF_OP_LOGIC_OR = 4'h9,
        ASF_OP_LOGIC_XOR = 4'hA,
        ASF_OP_BIT_CLEAR = 4'hB,
        ASF_OP_BIT_SET = 4'hC,
        ASF_OP_NIBBLE_SWAP = 4'hD,
        ASF_OP_MOVE = 4'hE
    } asf_op_t;

    typedef struct packed {
        logic valid;
        asf_op_t op;
        logic [7:0] opa;
        logic [7:0] opb;
        logic [2:0] bitsel;
        logic dest_flags;
    } asf_req_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] data;
    } asf_res_t;

endpackage

// ### sim/asf_alu_flags_chk.sv
`timescale 1ns/1ps
module asf_alu_flags_chk
    import asf_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire asf_req_t req,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [ASF_AW-1:0] reg_addr,
    input wire asf_res_t res,
    input wire logic [ASF_DW-1:0] reg_rdata,
    input wire logic [4:0] flags
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    logic ad;
    assign ad = req.valid && req.op inside
        {ASF_OP_ADD_ACC_TO_FILE, ASF_OP_ADD_LITERAL};
    // ----
    // Properties
    // ----
    property p_rv;
        req.valid |=> res.valid;
    endproperty
    a_rv: assert property (p_rv) else $error("no result");
    property p_rw;
        req.valid && req.dest_flags |=> res.valid && !res.write;
    endproperty
    a_rw: assert property (p_rw) else $error("result kept");
    property p_hi;
        reg_rd && reg_addr == ASF_FLAGS_ADDR |=> reg_rdata[7:5] == 3'h0;
    endproperty
    a_hi: assert property (p_hi) else $error("upper bits");
    property p_sz;
        ad |=> flags[4] == res.data[7] && flags[2] == (res.data == 8'h00);
    endproperty
    a_sz: assert property (p_sz) else $error("sign zero");
    property p_hc;
        ad |=> flags[1] == $past(req.opa[3:0] + req.opb[3:0] > 5'h0F);
    endproperty
    a_hc: assert property (p_hc) else $error("half carry");
    property p_cy;
        ad |=> flags[0] == $past(req.opa + req.opb > 9'h0FF);
    endproperty
    a_cy: assert property (p_cy) else $error("carry");
    property p_rr;
        req.valid && req.op == ASF_OP_ROTATE_RIGHT |=>
            flags[1:0] == $past({req.opa[4], req.opa[0]});
    endproperty
    a_rr: assert property (p_rr) else $error("rotate");
    property p_kp;
        req.valid && !req.dest_flags && !reg_wr && req.op inside
            {ASF_OP_MOVE, ASF_OP_BIT_SET} |=> $stable(flags);
    endproperty
    a_kp: assert property (p_kp) else $error("flag moved");
    c_add: cover property (ad);
    c_dst: cover property (req.valid && req.dest_flags);
    c_rd: cover property (reg_rd);
endmodule // asf_alu_flags_chk

bind asf_alu_flags asf_alu_flags_chk i_chk (.core_clk(core_clk),
    .reset(reset), .req(req), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .res(res), .reg_rdata(reg_rdata), .flags(flags));

// ### sim/asf_core_model.sv
`timescale 1ns/1ps
module asf_core_model
    import asf_pkg::*;
(
    input wire logic core_clk,
    output asf_req_t req
);
    initial req = '0;
    task automatic issue(input asf_op_t o, input logic [7:0] a, b,
        input logic d);
        @(posedge core_clk);
        req <= '{1'b1, o, a, b, 3'h0, d};
        @(posedge core_clk);
        // Operands lapse with valid, so scramble rather than hold
        req <= '{1'b0, ASF_OP_NONE, ~a, ~b, 3'h7, ~d};
    endtask
endmodule // asf_core_model

// ### sim/tb_asf_alu_flags.sv
`timescale 1ns/1ps
module tb_asf_alu_flags
    import asf_pkg::*;
();
    logic core_clk = 0;
    logic reset = 1;
    logic [3:0] reg_addr = '0;
    logic [7:0] reg_wdata = '0;
    logic reg_wr = 0;
    logic reg_rd = 0;
    asf_req_t req;
    asf_res_t res;
    logic [7:0] reg_rdata;
    logic [4:0] flags;
    int n_fail = 0;
    int tests_run = 0;
    asf_core_model i_asf_core_model (.core_clk(core_clk), .req(req));
    asf_alu_flags i_asf_alu_flags (.core_clk(core_clk), .reset(reset),
        .req(req), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .res(res),
        .reg_rdata(reg_rdata), .flags(flags));
    initial forever #5 core_clk = ~core_clk;
    // ----
    // Bus and compare tasks
    // ----
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e)
        begin
            n_fail++;
            $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1;
        @(posedge core_clk);
        reg_wr <= 0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1;
        @(posedge core_clk);
        reg_rd <= 0;
        #1 chk(reg_rdata, e);
    endtask
    task automatic op(input asf_op_t o, input logic [7:0] a, b,
        input logic d, input logic [7:0] er, input logic [4:0] ef);
        i_asf_core_model.issue(o, a, b, d);
        #1 chk({7'h0, res.valid}, 8'h01);
        chk({7'h0, res.write}, {7'h0, ~d});
        chk(res.data, er);
        chk({3'h0, flags}, {3'h0, ef});
    endtask
    // ----
    // Scenarios
    // ----
    task automatic t_reg();
        wr(ASF_FLAGS_ADDR, 8'hFF);
        rd(ASF_FLAGS_ADDR, 8'h1F);
        rd(4'h5, 8'h00);
    endtask
    task automatic t_arith();
        op(ASF_OP_ADD_ACC_TO_FILE, 8'h7F, 8'h01, 0, 8'h80, 5'h1A);
        op(ASF_OP_ADD_LITERAL, 8'hFF, 8'h01, 0, 8'h00, 5'h07);
        op(ASF_OP_FILE_MINUS_ACC, 8'h05, 8'h06, 0, 8'hFF, 5'h10);
        op(ASF_OP_LITERAL_MINUS_ACC, 8'h06, 8'h06, 0, 8'h00, 5'h07);
        op(ASF_OP_FILE_MINUS_ACC, 8'h05, 8'h00, 0, 8'h05, 5'h03);
    endtask
    task automatic t_rot();
        wr(ASF_FLAGS_ADDR, 8'h00);
        op(ASF_OP_ROTATE_RIGHT, 8'h11, 8'h00, 0, 8'h08, 5'h03);
        op(ASF_OP_ROTATE_LEFT, 8'h80, 8'h00, 0, 8'h01, 5'h01);
    endtask
    task automatic t_dest();
        wr(ASF_FLAGS_ADDR, 8'h1B);
        op(ASF_OP_CLEAR_FILE, 8'h5A, 8'h00, 1, 8'h00, 5'h1F);
        op(ASF_OP_ADD_ACC_TO_FILE, 8'h01, 8'h01, 1, 8'h02, 5'h00);
        op(ASF_OP_MOVE, 8'h5A, 8'h00, 0, 8'h5A, 5'h00);
        rd(ASF_FLAGS_ADDR, 8'h00);
        rd(ASF_LAST_ADDR, 8'h0E);
        op(ASF_OP_MOVE, 8'h15, 8'h00, 1, 8'h15, 5'h15);
    endtask
    task automatic test_done();
        $display("checks %0d failures %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        #5000;
        n_fail++;
        test_done();
    end
    initial
    begin
        repeat (10) @(posedge core_clk);
        reset <= 0;
        t_reg();
        t_arith();
        t_rot();
        t_dest();
        test_done();
    end
endmodule // tb_asf_alu_flags
